// >>> src/spi_pin_pkg.sv
// Shared constants and types for the select-line pin-state controller
package spi_pin_pkg;
    // Slave link states
    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_DESEL = 3'b001,
        ST_SELECTED = 3'b010,
        ST_BUSY = 3'b011,
        ST_PROACTIVE = 3'b100,
        ST_PSAVE = 3'b101
    } link_state_t;

    // Word size and transmit buffer shape
    localparam int WORD_W = 8;
    localparam int TX_DEPTH = 4;
    // Filler sent when the transmit buffer runs dry
    localparam logic [7:0] TX_IDLE_WORD = 8'hff;

    // Reset values
    localparam logic SEL_RELEASED = 1'b1;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;

    // Timing: request pulse window in ns, clock period in ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int REQ_WINDOW_NS = 10000;
    // Longest time rounds down, never below one cycle
    localparam int REQ_WINDOW_CYC = (REQ_WINDOW_NS / CLK_PERIOD_NS) < 1 ?
        1 : (REQ_WINDOW_NS / CLK_PERIOD_NS);
    localparam int REQ_CNT_W = 16;
endpackage

// >>> src/word_stream_if.sv
// Valid/ready word stream between the buffer and the shifter
`timescale 1ns/1ps
interface word_stream_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// >>> src/word_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    word_stream_if.snk fill,
    word_stream_if.src drain
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic not_full_reg;
    logic push;
    logic pop;

    // Index wrap, shared by both pointers
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push = fill.valid && not_full_reg;
    assign pop = drain.ready && (cnt_reg != '0);
    assign fill.ready = not_full_reg;
    assign drain.valid = (cnt_reg != '0);
    assign drain.data = mem_reg[rd_reg];

    always_comb begin
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    // Storage write; no reset needed on data
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= fill.data;
        end
    end

    // Pointers and occupancy; ready held in a flop for clean timing
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            not_full_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= bump(wr_reg);
            end
            if (pop) begin
                rd_reg <= bump(rd_reg);
            end
            cnt_reg <= cnt_next;
            not_full_reg <= (cnt_next != DEPTH_C);
        end
    end
endmodule

// >>> src/spi_pin_ctrl.sv
// Four-wire SPI slave pin-state controller with shared select line
`timescale 1ns/1ps
module spi_pin_ctrl #(
    parameter int REQ_WINDOW_CYC = spi_pin_pkg::REQ_WINDOW_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_shared_select_line,
    input wire logic i_link_clk,
    input wire logic i_mosi,
    output logic o_master_select_drive_n,
    output logic o_select_oe,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_config_done,
    input wire logic i_busy_capable,
    input wire logic i_busy_hold,
    input wire logic i_request,
    input wire logic i_power_save,
    input wire logic [spi_pin_pkg::WORD_W-1:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic [spi_pin_pkg::WORD_W-1:0] o_rx_data,
    output logic o_rx_valid,
    output spi_pin_pkg::link_state_t o_state
);
    localparam int W = spi_pin_pkg::WORD_W;
    localparam logic [2:0] BIT_CNT_ZERO = spi_pin_pkg::BIT_CNT_RESET;

    spi_pin_pkg::link_state_t state_reg;
    spi_pin_pkg::link_state_t state_next;
    logic [1:0] sel_sync_reg;
    logic [1:0] own_drive_reg;
    logic [2:0] clk_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic sel_low;
    logic clk_rise;
    logic clk_fall;
    logic shifting;
    logic drive_sel;
    logic [spi_pin_pkg::REQ_CNT_W-1:0] req_cnt_reg;
    logic req_done;
    logic [2:0] bit_cnt_reg;
    logic [W-1:0] rx_sh_reg;
    logic [W-1:0] tx_sh_reg;
    logic load_tx;

    word_stream_if #(.WIDTH(W)) tx_in ();
    word_stream_if #(.WIDTH(W)) tx_out ();

    assign tx_in.data = i_tx_data;
    assign tx_in.valid = i_tx_valid;
    assign o_tx_ready = tx_in.ready;

    // Transmit words wait here; a full buffer stalls the user side
    word_fifo #(
        .WIDTH(W),
        .DEPTH(spi_pin_pkg::TX_DEPTH)
    ) u_tx_fifo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .fill(tx_in),
        .drain(tx_out)
    );

    // Pins come from outside: two flops, the third for edge finding
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_sync_reg <= {2{spi_pin_pkg::SEL_RELEASED}};
            clk_sync_reg <= 3'h0;
            mosi_sync_reg <= 2'h0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], i_shared_select_line};
            clk_sync_reg <= {clk_sync_reg[1:0], i_link_clk};
            mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
        end
    end

    // Our own released drive lingers two cycles in the synchroniser;
    // blanking it costs a master two cycles of latency right after
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            own_drive_reg <= 2'h0;
        end else begin
            own_drive_reg <= {own_drive_reg[0], o_select_oe};
        end
    end

    assign sel_low = !sel_sync_reg[1] && (own_drive_reg == 2'h0);
    assign clk_rise = clk_sync_reg[1] && !clk_sync_reg[2];
    assign clk_fall = !clk_sync_reg[1] && clk_sync_reg[2];
    // Receiver runs only when selected, or busy with capability, so shared traffic is ignored
    assign shifting = (state_reg == spi_pin_pkg::ST_SELECTED) ||
        ((state_reg == spi_pin_pkg::ST_BUSY) && i_busy_capable);
    assign req_done = (req_cnt_reg == spi_pin_pkg::REQ_CNT_W'(
        REQ_WINDOW_CYC - 1));

    // State sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            spi_pin_pkg::ST_INIT: begin
                if (i_config_done) begin
                    state_next = spi_pin_pkg::ST_DESEL;
                end
            end
            spi_pin_pkg::ST_DESEL: begin
                if (sel_low && i_busy_hold) begin
                    state_next = spi_pin_pkg::ST_BUSY;
                end else if (sel_low) begin
                    state_next = spi_pin_pkg::ST_SELECTED;
                end else if (i_request) begin
                    state_next = spi_pin_pkg::ST_PROACTIVE;
                end else if (i_power_save) begin
                    state_next = spi_pin_pkg::ST_PSAVE;
                end
            end
            spi_pin_pkg::ST_SELECTED: begin
                if (!sel_low && i_busy_hold) begin
                    state_next = spi_pin_pkg::ST_BUSY;
                end else if (!sel_low) begin
                    state_next = spi_pin_pkg::ST_DESEL;
                end
            end
            spi_pin_pkg::ST_BUSY: begin
                if (!i_busy_hold) begin
                    state_next = spi_pin_pkg::ST_DESEL;
                end
            end
            spi_pin_pkg::ST_PROACTIVE: begin
                // Master overlap does not stretch the window
                if (req_done) begin
                    state_next = spi_pin_pkg::ST_DESEL;
                end
            end
            spi_pin_pkg::ST_PSAVE: begin
                // Leading select edge resumes the slave
                if (sel_low) begin
                    state_next = spi_pin_pkg::ST_SELECTED;
                end else if (!i_power_save) begin
                    state_next = spi_pin_pkg::ST_DESEL;
                end
            end
            default: state_next = spi_pin_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= spi_pin_pkg::ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request window timer, cleared outside the pro-active state
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            req_cnt_reg <= '0;
        end else if (state_reg == spi_pin_pkg::ST_PROACTIVE) begin
            req_cnt_reg <= req_cnt_reg + 1'b1;
        end else begin
            req_cnt_reg <= '0;
        end
    end

    // Select drive kept apart from the receiver path
    assign drive_sel = (state_next == spi_pin_pkg::ST_BUSY) ||
        (state_next == spi_pin_pkg::ST_PROACTIVE);
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_select_oe <= 1'b0;
            o_master_select_drive_n <= spi_pin_pkg::SEL_RELEASED;
        end else begin
            o_select_oe <= drive_sel;
            o_master_select_drive_n <= !drive_sel;
        end
    end

    // Data output enable by state
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_miso_oe <= 1'b0;
        end else begin
            o_miso_oe <= (state_next == spi_pin_pkg::ST_SELECTED) ||
                ((state_next == spi_pin_pkg::ST_BUSY) &&
                i_busy_capable);
        end
    end

    // Load a word on entry to a frame and after each full word
    assign load_tx = ((state_next == spi_pin_pkg::ST_SELECTED) &&
        (state_reg != spi_pin_pkg::ST_SELECTED)) ||
        (shifting && clk_fall && (bit_cnt_reg == BIT_CNT_ZERO));
    assign tx_out.ready = load_tx;

    // Mode 0 shifter: sample on rising edge, change on falling edge
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_cnt_reg <= spi_pin_pkg::BIT_CNT_RESET;
            rx_sh_reg <= '0;
            tx_sh_reg <= '0;
            o_miso <= 1'b0;
            o_rx_data <= '0;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= 1'b0;
            if (load_tx) begin
                // Empty buffer sends filler rather than stalling the master
                tx_sh_reg <= tx_out.valid ? tx_out.data :
                    spi_pin_pkg::TX_IDLE_WORD;
                o_miso <= tx_out.valid ? tx_out.data[W-1] :
                    spi_pin_pkg::TX_IDLE_WORD[W-1];
            end else if (shifting && clk_fall) begin
                tx_sh_reg <= {tx_sh_reg[W-2:0], 1'b0};
                o_miso <= tx_sh_reg[W-2];
            end
            if (!shifting) begin
                bit_cnt_reg <= spi_pin_pkg::BIT_CNT_RESET;
            end else if (clk_rise) begin
                rx_sh_reg <= {rx_sh_reg[W-2:0], mosi_sync_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                if (bit_cnt_reg == 3'h7) begin
                    o_rx_data <= {rx_sh_reg[W-2:0], mosi_sync_reg[1]};
                    o_rx_valid <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_state <= spi_pin_pkg::ST_INIT;
        end else begin
            o_state <= state_next;
        end
    end
endmodule

// >>> verif/pin_ctrl_monitor.sv
// Assertion checker for the select-line pin-state controller
`timescale 1ns/1ps
module pin_ctrl_monitor #(
    parameter int REQ_WINDOW_CYC = spi_pin_pkg::REQ_WINDOW_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_shared_select_line,
    input wire logic i_busy_capable,
    input wire logic i_busy_hold,
    input wire logic i_request,
    input wire logic i_power_save,
    input wire logic o_master_select_drive_n,
    input wire logic o_select_oe,
    input wire logic o_miso_oe,
    input wire spi_pin_pkg::link_state_t o_state
);
    int pro_cnt_reg;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Cycles already spent in the request state
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pro_cnt_reg <= 0;
        end else if (o_state == spi_pin_pkg::ST_PROACTIVE) begin
            pro_cnt_reg <= pro_cnt_reg + 1;
        end else begin
            pro_cnt_reg <= 0;
        end
    end
    // Master pulls select while the slave is idle
    sequence pulled(logic h);
        o_state == spi_pin_pkg::ST_DESEL && !i_shared_select_line &&
            !i_request && !i_power_save && i_busy_hold == h;
    endsequence
    a_init_quiet: assert property (
        o_state == spi_pin_pkg::ST_INIT |-> !o_miso_oe && !o_select_oe)
        else $error("pin driven before configuration");
    a_miso_state: assert property (
        o_miso_oe |-> o_state inside {spi_pin_pkg::ST_SELECTED,
            spi_pin_pkg::ST_BUSY})
        else $error("data out driven in wrong state");
    a_busy_cap: assert property (
        o_state == spi_pin_pkg::ST_BUSY && $stable(i_busy_capable)
            |-> o_miso_oe == i_busy_capable)
        else $error("busy data drive ignores capability");
    a_idle_float: assert property (
        o_state inside {spi_pin_pkg::ST_DESEL, spi_pin_pkg::ST_PSAVE}
            |-> !o_select_oe)
        else $error("select driven while idle");
    a_busy_drive: assert property (
        o_state == spi_pin_pkg::ST_BUSY
            |-> o_select_oe && !o_master_select_drive_n)
        else $error("busy without select drive");
    a_pro_window: assert property (
        o_state == spi_pin_pkg::ST_PROACTIVE
            |-> pro_cnt_reg < REQ_WINDOW_CYC)
        else $error("request held past its window");
    a_sel_owner: assert property (
        o_select_oe |-> o_state inside {spi_pin_pkg::ST_BUSY,
            spi_pin_pkg::ST_PROACTIVE})
        else $error("select driven outside busy or request");
    a_grab_busy: assert property (
        pulled(1'b1) [*3] |-> ##[0:1] o_state == spi_pin_pkg::ST_BUSY)
        else $error("joint assertion did not give busy");
    a_sel_enter: assert property (
        pulled(1'b0) [*3] |-> ##[0:1]
            o_state == spi_pin_pkg::ST_SELECTED && o_miso_oe)
        else $error("selection not taken");
endmodule
bind spi_pin_ctrl pin_ctrl_monitor #(.REQ_WINDOW_CYC(REQ_WINDOW_CYC)) i_mon (
    .i_clk, .i_nrst, .i_shared_select_line, .i_busy_capable, .i_busy_hold,
    .i_request, .i_power_save, .o_master_select_drive_n, .o_select_oe,
    .o_miso_oe, .o_state);

// >>> verif/spi_master_model.sv
// Behavioural SPI master on the shared select, clock and data lines
`timescale 1ns/1ps
module spi_master_model (
    input wire logic i_sel_line,
    input wire logic i_miso,
    output logic o_sel_drive,
    output logic o_link_clk,
    output logic o_mosi
);
    initial begin
        o_sel_drive = 1'b0;
        o_link_clk = 1'b0;
        o_mosi = 1'b0;
    end
    task automatic hold_sel(input logic v);
        o_sel_drive = v;
    endtask
    // Mode 0 byte, MSB first; own low talks to some other slave
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
            output logic ok, input logic own);
        int n;
        n = 0;
        // Keep pin changes off the system clock edges
        #25;
        // Select may be held low by a busy slave; poll until free
        while (i_sel_line !== 1'b1 && n < 200) begin
            #100 n++;
        end
        ok = n < 200;
        o_sel_drive = own;
        #1200;
        for (int i = 7; i >= 0; i--) begin
            o_mosi = tx[i];
            #400 o_link_clk = 1'b1;
            rx[i] = i_miso;
            #400 o_link_clk = 1'b0;
        end
        #400 o_sel_drive = 1'b0;
        o_mosi = ~o_mosi; // Released line does not keep its bit
        #1000;
    endtask
endmodule

// >>> verif/spi_pin_ctrl_bench.sv
// Self-checking bench for the select-line pin-state controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
    checked++; \
    if ((a) !== (e)) begin \
        fail_count++; \
        $display("unexpected %s: expected %h seen %h", n, e, a); \
    end \
end
module spi_pin_ctrl_bench;
    localparam int WIN = 5;
    logic clk, nrst, cfg, cap, hold, req, psave, tx_valid, tog, ok;
    logic sel_n, sel_oe, miso, miso_oe, tx_ready, rx_valid;
    logic m_sel, m_clk, m_mosi, sel_line, miso_line;
    logic [7:0] tx_data, rx_data, got, rx;
    logic [7:0] words [4] = '{8'h10, 8'h21, 8'h32, 8'h43};
    spi_pin_pkg::link_state_t state;
    int fail_count, checked;
    // Pull-up on select; undriven data out shows a moving pattern
    assign sel_line = !(m_sel || (sel_oe && !sel_n));
    assign miso_line = miso_oe ? miso : tog;
    spi_pin_ctrl #(.REQ_WINDOW_CYC(WIN)) i_spi_pin_ctrl (
        .i_clk(clk), .i_nrst(nrst), .i_shared_select_line(sel_line),
        .i_link_clk(m_clk), .i_mosi(m_mosi), .o_master_select_drive_n(sel_n),
        .o_select_oe(sel_oe), .o_miso(miso), .o_miso_oe(miso_oe),
        .i_config_done(cfg), .i_busy_capable(cap), .i_busy_hold(hold),
        .i_request(req), .i_power_save(psave), .i_tx_data(tx_data),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .o_state(state));
    spi_master_model i_spi_master_model (.i_sel_line(sel_line),
        .i_miso(miso_line), .o_sel_drive(m_sel), .o_link_clk(m_clk),
        .o_mosi(m_mosi));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Keep the last received word; pattern toggles every cycle
    always @(posedge clk) begin
        tog <= ~tog;
        if (rx_valid === 1'b1) got <= rx_data;
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_st(input spi_pin_pkg::link_state_t st);
        int n;
        n = 0;
        while (state !== st && n < 300) begin
            @(posedge clk) #1 n++;
        end
        if (n == 300) begin
            fail_count++;
            $display("unexpected state: expected %h seen %h", st, state);
            test_done();
        end
    endtask
    task automatic t_init();
        i_spi_master_model.xfer(8'h3c, rx, ok, 1'b1);
        `CHK("init data oe", 1'b0, miso_oe)
        `CHK("init word", 8'h00, got)
        @(posedge clk) cfg <= 1'b1;
        wait_st(spi_pin_pkg::ST_DESEL);
        i_spi_master_model.xfer(8'h5a, rx, ok, 1'b0);
        `CHK("foreign word", 8'h00, got)
        $display("init and foreign traffic done");
    endtask
    task automatic t_fifo();
        int n, k;
        n = 0;
        k = 0;
        @(posedge clk) tx_valid <= 1'b1;
        tx_data <= words[0];
        while (n < 4 && k++ < 20) begin
            @(posedge clk);
            if (tx_ready === 1'b1) begin
                n++;
                tx_data <= words[n % 4];
            end
        end
        tx_valid <= 1'b0;
        @(posedge clk) #1 `CHK("full refuses", 1'b0, tx_ready)
        for (int i = 0; i < 5; i++) begin
            i_spi_master_model.xfer(8'hc0 + 8'(i), rx, ok, 1'b1);
            // A frame takes a word on entry and one after its eighth bit
            `CHK("tx word", i < 2 ? words[2 * i] : spi_pin_pkg::TX_IDLE_WORD,
                rx)
            `CHK("rx word", 8'hc0 + 8'(i), got)
        end
        $display("buffer fill and drain done");
    endtask
    task automatic t_busy(input logic c);
        @(posedge clk) cap <= c;
        fork
            i_spi_master_model.xfer(8'h77, rx, ok, 1'b1);
            begin
                wait_st(spi_pin_pkg::ST_SELECTED);
                @(posedge clk) hold <= 1'b1;
            end
        join
        wait_st(spi_pin_pkg::ST_BUSY);
        `CHK("busy select", 2'b10, {sel_oe, sel_n})
        `CHK("busy data oe", c, miso_oe)
        fork
            i_spi_master_model.xfer(8'h88, rx, ok, 1'b1);
            begin
                repeat (20) @(posedge clk);
                #1 `CHK("stays busy", spi_pin_pkg::ST_BUSY, state)
                @(posedge clk) hold <= 1'b0;
            end
        join
        `CHK("master waited", 1'b1, ok)
        `CHK("word after busy", 8'h88, got)
        $display("busy with capability %0d done", c);
    endtask
    task automatic t_pro(input logic r);
        int n;
        n = 0;
        @(posedge clk) req <= 1'b1;
        @(posedge clk) req <= 1'b0;
        #1 wait_st(spi_pin_pkg::ST_PROACTIVE);
        i_spi_master_model.hold_sel(r);
        `CHK("request drive", 2'b10, {sel_oe, sel_n})
        while (state === spi_pin_pkg::ST_PROACTIVE && n < 50) begin
            @(posedge clk) #1 n++;
        end
        `CHK("window length", WIN, n)
        `CHK("after window", spi_pin_pkg::ST_DESEL, state)
        // Own released drive must not read as a master selection
        repeat (2) @(posedge clk);
        #1 `CHK("no false select", spi_pin_pkg::ST_DESEL, state)
        if (r) wait_st(spi_pin_pkg::ST_SELECTED);
        `CHK("master takes over", r ? spi_pin_pkg::ST_SELECTED :
            spi_pin_pkg::ST_DESEL, state)
        i_spi_master_model.hold_sel(1'b0);
        wait_st(spi_pin_pkg::ST_DESEL);
        $display("request with master %0d done", r);
    endtask
    task automatic t_grab();
        // Without capability the busy slave ignores the clock
        @(posedge clk) hold <= 1'b1;
        cap <= 1'b0;
        i_spi_master_model.xfer(8'h99, rx, ok, 1'b1);
        `CHK("joint grab", spi_pin_pkg::ST_BUSY, state)
        `CHK("no transfer", 8'h88, got)
        @(posedge clk) hold <= 1'b0;
        wait_st(spi_pin_pkg::ST_DESEL);
        $display("joint assertion done");
    endtask
    task automatic t_psave();
        @(posedge clk) psave <= 1'b1;
        wait_st(spi_pin_pkg::ST_PSAVE);
        i_spi_master_model.xfer(8'h24, rx, ok, 1'b0);
        `CHK("psave select oe", 1'b0, sel_oe)
        i_spi_master_model.xfer(8'h42, rx, ok, 1'b1);
        `CHK("resume word", 8'h42, got)
        @(posedge clk) psave <= 1'b0;
        wait_st(spi_pin_pkg::ST_DESEL);
        $display("power saving done");
    endtask
    initial begin
        fail_count = 0;
        checked = 0;
        {nrst, cfg, cap, hold, req, psave, tx_valid, tog} = '0;
        tx_data = 8'h00;
        got = 8'h00;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_init();
        t_fifo();
        t_busy(1'b0);
        t_busy(1'b1);
        t_pro(1'b0);
        t_pro(1'b1);
        t_grab();
        t_psave();
        test_done();
    end
endmodule
